/* bench/pri_checker_assertions.sv */
`timescale 1ns/1ps
module pri_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_prot_mode,
  input wire logic i_avail,
  input wire logic i_ins_valid,
  input wire logic o_ins_ready,
  input wire logic i_ins_kind,
  input wire logic i_op2_is_mem,
  input wire logic o_op2_req,
  input wire logic o_mem_req,
  input wire logic o_done,
  input wire logic o_ud,
  input wire logic o_fault,
  input wire logic o_cf_we,
  input wire logic o_irq,
  input wire logic o_retired
);
  default clocking cb_clk @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire  take = i_ins_valid && o_ins_ready;
  logic kind_r;
  logic mem_r;
  // The finish of an instruction is judged by what was accepted, since inputs move on after take.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      kind_r <= 1'b0;
      mem_r  <= 1'b0;
    end else if (take) begin
      kind_r <= i_ins_kind;
      mem_r  <= i_op2_is_mem;
    end
  end
  property p_ud_take;
    take && !(i_prot_mode && i_avail) |=> o_done && o_ud && !o_mem_req;
  endproperty
  a_ud_take: assert property (p_ud_take) else $error("invalid opcode missing");
  property p_ud_done;
    o_ud |-> o_done && !o_cf_we && !o_irq;
  endproperty
  a_ud_done: assert property (p_ud_done) else $error("invalid opcode finish wrong");
  property p_vs_flags;
    o_done && !kind_r |-> !o_cf_we;
  endproperty
  a_vs_flags: assert property (p_vs_flags) else $error("value sample wrote carry");
  property p_ins_cf;
    o_done && !o_ud && kind_r |-> o_cf_we;
  endproperty
  a_ins_cf: assert property (p_ins_cf) else $error("user record left carry alone");
  property p_retired;
    o_done && !o_ud |-> o_retired;
  endproperty
  a_retired: assert property (p_retired) else $error("finish not retired");
  property p_irq;
    o_irq |-> o_done && !o_ud;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt outside a store");
  property p_op2;
    $rose(o_op2_req) |-> mem_r && !o_done;
  endproperty
  a_op2: assert property (p_op2) else $error("operand fetch without memory operand");
  property p_fault;
    o_fault |-> !o_done ##1 !o_done;
  endproperty
  a_fault: assert property (p_fault) else $error("fault followed by finish");
endmodule
bind pri_profiling_unit pri_checker u_pri_checker (.i_clk, .i_reset, .i_prot_mode, .i_avail,
  .i_ins_valid, .o_ins_ready, .i_ins_kind, .i_op2_is_mem, .o_op2_req, .o_mem_req, .o_done,
  .o_ud, .o_fault, .o_cf_we, .o_irq, .o_retired);

/* bench/pri_mem_model.sv */
`timescale 1ns/1ps
module pri_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_slow,
  input  wire logic        i_ro,
  output logic             o_ack,
  output logic             o_fault,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_r;
  // Reserved words start at zero, as consumer software leaves them.
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end
  // Slow mode stretches each access so the unit must wait on the ack, not on a count.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ack   <= 1'b0;
      o_fault <= 1'b0;
      wait_r  <= 2'h0;
      o_rdata <= 32'h0;
    end else begin
      o_ack   <= 1'b0;
      o_fault <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
        if (i_slow && wait_r != 2'h3) wait_r <= wait_r + 2'h1;
        else begin
          wait_r <= 2'h0;
          o_ack  <= 1'b1;
          if (i_ro && i_we) o_fault <= 1'b1;
          else if (i_we) mem[i_addr[9:2]] <= i_wdata;
          else o_rdata <= mem[i_addr[9:2]];
        end
      end
    end
  end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, i_op2_reg, i_imm, i_op2_mem;
  logic [3:0]  s_axi_wstrb;
  logic        i_prot_mode, i_avail, i_ins_valid, i_ins_kind, i_op1_is32, i_op2_is_mem;
  logic        i_op2_valid, mem_slow, mem_ro;
  logic [63:0] i_op1, i_ins_addr, op1_v, addr_v;
  logic [31:0] op2_v, imm_v, rd_d;
  logic [1:0]  rd_r;
  logic [3:0]  exp_q [$];
  int          error_cnt = 0, check_count = 0, seed = 34, op2_cnt = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
  wire         o_ins_ready, o_op2_req, o_mem_req, o_mem_we, i_mem_ack, i_mem_fault;
  wire         o_done, o_ud, o_fault, o_cf_we, o_cf, o_irq, o_retired;

  pri_profiling_unit u_pri_profiling_unit (.i_clk, .i_reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_prot_mode, .i_avail, .i_ins_valid,
    .o_ins_ready, .i_ins_kind, .i_op1, .i_op1_is32, .i_op2_is_mem, .i_op2_reg, .i_imm,
    .i_ins_addr, .o_op2_req, .i_op2_valid, .i_op2_mem, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .i_mem_ack, .i_mem_fault, .i_mem_rdata, .o_done, .o_ud, .o_fault, .o_cf_we,
    .o_cf, .o_irq, .o_retired);
  pri_mem_model u_pri_mem_model (.i_clk, .i_reset, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_slow(mem_slow), .i_ro(mem_ro),
    .o_ack(i_mem_ack), .o_fault(i_mem_fault), .o_rdata(i_mem_rdata));

  always #10 i_clk = ~i_clk;

  task give_verdict;
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    error_cnt++;
    give_verdict;
  endtask
  // Write address and data go out together; each is dropped once its own handshake lands.
  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(negedge i_clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge i_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) begin
        s_axi_bready <= 1'b0;
        chk(r, er);
        return;
      end
    end
    tmo;
  endtask
  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(negedge i_clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge i_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo;
  endtask
  task rd_chk(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    axi_rd(a, rd_d, rd_r);
    chk({rd_r, rd_d}, {er, ed});
  endtask
  // Enabling polls status because the control block load of seven accesses takes an unknown number of cycles.
  task enable;
    axi_wr(32'h0, 32'h200, 2'h0);
    for (int n = 0; n < 100; n++) begin
      axi_rd(32'h4, rd_d, rd_r);
      if (rd_d[1:0] == 2'h1) break;
    end
    chk(rd_d[1:0], 2'h1);
  endtask
  // Operands are random; the expected finish {ud, cf_we, cf, irq} is queued unless a fault is due.
  task ins(input logic k, input logic m, input logic s32, input logic [4:0] e);
    logic t, d, f;
    op1_v = {$random(seed), $random(seed)};
    addr_v = {$random(seed), $random(seed)};
    op2_v = $random(seed);
    imm_v = $random(seed);
    if (!e[4]) exp_q.push_back(e[3:0]);
    @(posedge i_clk);
    i_ins_valid <= 1'b1;
    i_ins_kind <= k;
    i_op1 <= op1_v;
    i_op1_is32 <= s32;
    i_op2_is_mem <= m;
    i_op2_reg <= op2_v;
    i_op2_mem <= op2_v;
    i_imm <= imm_v;
    i_ins_addr <= addr_v;
    for (int n = 0; n < 400; n++) begin
      @(negedge i_clk);
      t = i_ins_valid && o_ins_ready;
      d = o_done;
      f = o_fault;
      @(posedge i_clk);
      if (t) i_ins_valid <= 1'b0;
      if (d || f) begin
        chk(f, e[4]);
        return;
      end
    end
    tmo;
  endtask
  task rec_chk(input int slot, input logic [7:0] ev, input logic s32);
    int b;
    b = 64 + slot * 8;
    chk(u_pri_mem_model.mem[b], {imm_v[15:0], 8'h00, ev});
    chk(u_pri_mem_model.mem[b+1], op2_v);
    chk({u_pri_mem_model.mem[b+3], u_pri_mem_model.mem[b+2]}, addr_v);
    chk({u_pri_mem_model.mem[b+5], u_pri_mem_model.mem[b+4]},
        s32 ? {32'h0, op1_v[31:0]} : op1_v);
  endtask

  // The core answers an operand fetch one cycle after it is asked, and counts fetches.
  always @(posedge i_clk) begin
    i_op2_valid <= o_op2_req && !i_op2_valid;
    if (o_op2_req && !i_op2_valid) op2_cnt <= op2_cnt + 1;
  end
  // Each finish is matched against the oldest queued expectation.
  always @(negedge i_clk) begin
    if (o_done === 1'b1) begin
      if (exp_q.size() == 0) chk(64'h1, 64'h0);
      else chk({o_ud, o_cf_we, o_cf, o_irq}, exp_q.pop_front());
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, i_op2_reg, i_imm, i_op2_mem} = 192'h0;
    s_axi_wstrb = 4'hf;
    {i_ins_valid, i_ins_kind, i_op1_is32, i_op2_is_mem} = 4'h0;
    {i_prot_mode, i_avail, mem_slow, mem_ro} = 4'hc;
    {i_op1, i_ins_addr} = 128'h0;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int a = 0; a < 20; a += 4) rd_chk(a, 32'h0, a < 16 ? 2'h0 : 2'h2);
    axi_wr(32'h14, 32'h1, 2'h2);
    ins(1'b1, 1'b0, 1'b0, 5'h04);
    ins(1'b0, 1'b1, 1'b0, 5'h00);
    for (int k = 0; k < 3; k++) begin
      i_prot_mode <= k[0];
      i_avail <= k[1];
      ins(k[0], 1'b0, 1'b0, 5'h08);
    end
    i_prot_mode <= 1'b1;
    i_avail <= 1'b1;
    // Three-slot synchronized ring, tail 0 at byte 64, interval 1 at byte 128, counter 0.
    u_pri_mem_model.mem[128] = 32'h8000_0002;
    u_pri_mem_model.mem[129] = 32'h0000_0060;
    u_pri_mem_model.mem[130] = 32'h0000_0100;
    u_pri_mem_model.mem[136] = 32'h0000_0020;
    u_pri_mem_model.mem[160] = 32'h0000_0001;
    enable;
    ins(1'b1, 1'b0, 1'b0, 5'h04);
    rec_chk(0, 8'hff, 1'b0);
    mem_slow <= 1'b1;
    ins(1'b0, 1'b1, 1'b1, 5'h01);
    rec_chk(1, 8'h01, 1'b1);
    chk(op2_cnt, 1);
    ins(1'b0, 1'b1, 1'b0, 5'h00);
    chk(op2_cnt, 1);
    mem_slow <= 1'b0;
    ins(1'b0, 1'b0, 1'b0, 5'h00);
    rec_chk(1, 8'h01, 1'b0);
    ins(1'b1, 1'b0, 1'b0, 5'h06);
    rec_chk(1, 8'hff, 1'b0);
    rd_chk(32'h8, 32'h40, 2'h0);
    rd_chk(32'hc, 32'h2, 2'h0);
    chk(u_pri_mem_model.mem[134], 32'h2);
    axi_wr(32'h0, 32'h0, 2'h0);
    u_pri_mem_model.mem[128] = 32'ha000_0002;
    u_pri_mem_model.mem[132] = 32'h0000_0040;
    enable;
    rd_chk(32'hc, 32'h2, 2'h0);
    ins(1'b1, 1'b0, 1'b0, 5'h04);
    rec_chk(2, 8'hff, 1'b0);
    rd_chk(32'h8, 32'h0, 2'h0);
    rd_chk(32'hc, 32'h3, 2'h0);
    chk(u_pri_mem_model.mem[134], 32'h3);
    mem_ro <= 1'b1;
    ins(1'b1, 1'b0, 1'b0, 5'h10);
    chk(exp_q.size(), 0);
    give_verdict;
  end
endmodule

/* hdl/pri_profiling_unit.v */
`timescale 1ns/1ps
`include "pri_regs.vh"
module pri_profiling_unit (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        i_prot_mode,
  input  wire        i_avail,
  input  wire        i_ins_valid,
  output wire        o_ins_ready,
  input  wire        i_ins_kind,
  input  wire [63:0] i_op1,
  input  wire        i_op1_is32,
  input  wire        i_op2_is_mem,
  input  wire [31:0] i_op2_reg,
  input  wire [31:0] i_imm,
  input  wire [63:0] i_ins_addr,
  output reg         o_op2_req,
  input  wire        i_op2_valid,
  input  wire [31:0] i_op2_mem,
  output reg         o_mem_req,
  output reg         o_mem_we,
  output reg  [31:0] o_mem_addr,
  output reg  [31:0] o_mem_wdata,
  input  wire        i_mem_ack,
  input  wire        i_mem_fault,
  input  wire [31:0] i_mem_rdata,
  output reg         o_done,
  output reg         o_ud,
  output reg         o_fault,
  output reg         o_cf_we,
  output reg         o_cf,
  output reg         o_irq,
  output reg         o_retired
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_LOAD = 8'h02;
  localparam [7:0] S_OP2  = 8'h04;
  localparam [7:0] S_TAIL = 8'h08;
  localparam [7:0] S_REC  = 8'h10;
  localparam [7:0] S_HEAD = 8'h20;
  localparam [7:0] S_MISS = 8'h40;
  localparam [7:0] S_FIN  = 8'h80;

  reg [7:0]  st_r;
  reg        en_r;
  reg [31:0] cbaddr_r, flags_r, size_r, base_r, head_r, tail_r;
  reg [31:0] thr_r, intv_r, cnt_r, missed_r, slot_r, nhead_r;
  reg [3:0]  rand_r;
  reg [2:0]  idx_r;
  reg        kind_r, is32_r, adv_r, miss_r, ovw_r;
  reg [63:0] op1_r, iaddr_r;
  reg [31:0] op2_r, imm_r;
  reg [15:0] lfsr_r;
  reg        aw_r, w_r;
  reg [31:0] awa_r, wd_r;
  reg [31:0] rec_w;

  // Offsets fetched while loading the control block at enable.
  function [7:0] ld_off;
    input [2:0] i;
    begin
      case (i)
        3'h0: ld_off = `PRI_CB_FLAGS;
        3'h1: ld_off = `PRI_CB_SIZE;
        3'h2: ld_off = `PRI_CB_BASE;
        3'h3: ld_off = `PRI_CB_HEAD;
        3'h4: ld_off = `PRI_CB_THRESH;
        3'h5: ld_off = `PRI_CB_INTV1;
        default: ld_off = `PRI_CB_CNT1;
      endcase
    end
  endfunction

  // Ring offset arithmetic modulo the buffer size, used once, for the threshold interrupt.
  function [31:0] ring_fill;
    input [31:0] h;
    input [31:0] t;
    input [31:0] sz;
    begin
      ring_fill = (h >= t) ? h - t : h + sz - t;
    end
  endfunction

  wire [31:0] cnt_dec  = cnt_r - 32'h0000_0001;
  wire [31:0] head_inc = head_r + `PRI_REC_BYTES;
  wire [31:0] head_nx  = (head_inc >= size_r) ? 32'h0 : head_inc;
  wire [31:0] head_pv  = (head_r == 32'h0) ? size_r - `PRI_REC_BYTES
                                           : head_r - `PRI_REC_BYTES;
  wire        full_w   = (head_nx == i_mem_rdata);
  wire        cont_w   = flags_r[`PRI_FLG_CONT];
  wire [15:0] rmask    = (16'h0001 << rand_r) - 16'h0001;
  wire        mem_fin  = o_mem_req & i_mem_ack;
  wire        take_ins = i_ins_valid & o_ins_ready;
  wire        take_wr  = aw_r & w_r & ~s_axi_bvalid & st_r[0];

  // An instruction waits while a register write commits, so an accepted one is never dropped.
  assign o_ins_ready   = st_r[0] & ~take_wr;
  assign s_axi_awready = ~aw_r;
  assign s_axi_wready  = ~w_r;
  assign s_axi_arready = ~s_axi_rvalid;

  // Record words; words 2 and 3 hold the instruction address, 6 and 7 are zero.
  always @* begin
    case (idx_r)
      3'h0: rec_w = {imm_r[15:0], 8'h00,
                     kind_r ? `PRI_EVID_INS : `PRI_EVID_VAL};
      3'h1: rec_w = op2_r;
      3'h2: rec_w = iaddr_r[31:0];
      3'h3: rec_w = iaddr_r[63:32];
      3'h4: rec_w = op1_r[31:0];
      3'h5: rec_w = is32_r ? 32'h0 : op1_r[63:32];
      default: rec_w = 32'h0;
    endcase
  end

  // AXI4-Lite address and data are latched separately, in either order.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 32'h0;
      wd_r <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PRI_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PRI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_r) begin
        aw_r <= 1'b1;
        awa_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_r) begin
        w_r <= 1'b1;
        wd_r <= s_axi_wdata;
      end
      if (take_wr) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_r[31:4] == 28'h0 && awa_r[3:0] == `PRI_R_CBADDR)
                       ? `PRI_RESP_OKAY : `PRI_RESP_SLV;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & ~s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PRI_RESP_OKAY;
        if (s_axi_araddr[31:4] != 28'h0) begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PRI_RESP_SLV;
        end else if (s_axi_araddr[3:0] == `PRI_R_CBADDR) begin
          s_axi_rdata <= cbaddr_r;
        end else if (s_axi_araddr[3:0] == `PRI_R_STATUS) begin
          s_axi_rdata <= {30'h0, st_r[1], en_r};
        end else if (s_axi_araddr[3:0] == `PRI_R_HEAD) begin
          s_axi_rdata <= head_r;
        end else if (s_axi_araddr[3:0] == `PRI_R_MISSED) begin
          s_axi_rdata <= missed_r;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PRI_RESP_SLV;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Main sequencer. Memory requests hold until acknowledged; a fault aborts.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= S_IDLE;
      en_r <= 1'b0;
      cbaddr_r <= 32'h0;
      flags_r <= 32'h0;
      size_r <= 32'h0;
      base_r <= 32'h0;
      head_r <= 32'h0;
      tail_r <= 32'h0;
      thr_r <= 32'h0;
      intv_r <= 32'h0;
      cnt_r <= 32'h0;
      missed_r <= 32'h0;
      slot_r <= 32'h0;
      nhead_r <= 32'h0;
      rand_r <= 4'h0;
      idx_r <= 3'h0;
      kind_r <= 1'b0;
      is32_r <= 1'b0;
      adv_r <= 1'b0;
      miss_r <= 1'b0;
      ovw_r <= 1'b0;
      op1_r <= 64'h0;
      iaddr_r <= 64'h0;
      op2_r <= 32'h0;
      imm_r <= 32'h0;
      lfsr_r <= 16'hace1;
      o_op2_req <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 32'h0;
      o_mem_wdata <= 32'h0;
      o_done <= 1'b0;
      o_ud <= 1'b0;
      o_fault <= 1'b0;
      o_cf_we <= 1'b0;
      o_cf <= 1'b0;
      o_irq <= 1'b0;
      o_retired <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      o_done <= 1'b0;
      o_ud <= 1'b0;
      o_fault <= 1'b0;
      o_cf_we <= 1'b0;
      o_irq <= 1'b0;
      o_retired <= 1'b0;
      if (mem_fin) begin
        o_mem_req <= 1'b0;
      end
      if (mem_fin & i_mem_fault) begin
        o_fault <= 1'b1;
        if (st_r[1]) begin
          en_r <= 1'b0;
        end
        st_r <= S_IDLE;
      end else begin
        case (st_r)
          S_IDLE: begin
            if (take_wr & awa_r[31:4] == 28'h0 & awa_r[3:0] == `PRI_R_CBADDR) begin
              cbaddr_r <= wd_r;
              en_r <= 1'b0;
              idx_r <= 3'h0;
              if (wd_r != 32'h0) begin
                st_r <= S_LOAD;
              end
            end else if (take_ins) begin
              kind_r <= i_ins_kind;
              is32_r <= i_op1_is32;
              op1_r <= i_op1;
              op2_r <= i_op2_reg;
              imm_r <= i_imm;
              iaddr_r <= i_ins_addr;
              if (~i_prot_mode | ~i_avail) begin
                o_ud <= 1'b1;
                o_done <= 1'b1;
              end else if (~i_ins_kind & (~en_r | ~flags_r[`PRI_FLG_VALEV])) begin
                st_r <= S_FIN;
              end else if (i_ins_kind & ~en_r) begin
                o_cf_we <= 1'b1;
                o_cf <= 1'b0;
                o_done <= 1'b1;
                o_retired <= 1'b1;
              end else if (~i_ins_kind & ~cnt_dec[31]) begin
                cnt_r <= cnt_dec;
                st_r <= S_FIN;
              end else begin
                if (~i_ins_kind) begin
                  cnt_r <= cnt_dec;
                end
                o_op2_req <= i_op2_is_mem;
                st_r <= i_op2_is_mem ? S_OP2 : S_TAIL;
              end
            end
          end
          S_LOAD: begin
            if (~o_mem_req) begin
              o_mem_req <= 1'b1;
              o_mem_we <= 1'b0;
              o_mem_addr <= cbaddr_r + {24'h0, ld_off(idx_r)};
            end else if (mem_fin) begin
              idx_r <= idx_r + 3'h1;
              case (idx_r)
                3'h0: flags_r <= i_mem_rdata;
                3'h1: begin
                  size_r <= {4'h0, i_mem_rdata[27:5], 5'h00};
                  rand_r <= i_mem_rdata[31:28];
                end
                3'h2: base_r <= i_mem_rdata;
                3'h3: head_r <= i_mem_rdata;
                3'h4: thr_r <= i_mem_rdata;
                3'h5: intv_r <= i_mem_rdata;
                default: cnt_r <= i_mem_rdata;
              endcase
              if (idx_r == `PRI_LOAD_LAST) begin
                en_r <= 1'b1;
                st_r <= S_IDLE;
              end
            end
          end
          S_OP2: begin
            if (i_op2_valid) begin
              o_op2_req <= 1'b0;
              op2_r <= i_op2_mem;
              st_r <= S_TAIL;
            end
          end
          // The consumer's tail is re-read before every store.
          S_TAIL: begin
            if (~o_mem_req) begin
              o_mem_req <= 1'b1;
              o_mem_we <= 1'b0;
              o_mem_addr <= cbaddr_r + {24'h0, `PRI_CB_TAIL};
            end else if (mem_fin) begin
              tail_r <= i_mem_rdata;
              adv_r <= ~full_w | cont_w;
              ovw_r <= full_w & ~cont_w;
              miss_r <= (full_w & ~cont_w) | (cont_w & full_w);
              slot_r <= (full_w & ~cont_w) ? head_pv : head_r;
              nhead_r <= head_nx;
              idx_r <= 3'h0;
              st_r <= S_REC;
            end
          end
          S_REC: begin
            if (~o_mem_req) begin
              o_mem_req <= 1'b1;
              o_mem_we <= 1'b1;
              o_mem_addr <= base_r + slot_r + {27'h0, idx_r, 2'b00};
              o_mem_wdata <= rec_w;
            end else if (mem_fin) begin
              idx_r <= idx_r + 3'h1;
              if (idx_r == `PRI_REC_LAST) begin
                st_r <= adv_r ? S_HEAD : S_MISS;
              end
            end
          end
          // Head is flushed after each advance so consumers see progress.
          S_HEAD: begin
            if (~o_mem_req) begin
              o_mem_req <= 1'b1;
              o_mem_we <= 1'b1;
              o_mem_addr <= cbaddr_r + {24'h0, `PRI_CB_HEAD};
              o_mem_wdata <= nhead_r;
            end else if (mem_fin) begin
              head_r <= nhead_r;
              if (~kind_r) begin
                cnt_r <= (intv_r & ~{16'h0, rmask}) | {16'h0, lfsr_r & rmask};
              end
              st_r <= miss_r ? S_MISS : S_FIN;
            end
          end
          S_MISS: begin
            if (~o_mem_req) begin
              o_mem_req <= 1'b1;
              o_mem_we <= 1'b1;
              o_mem_addr <= cbaddr_r + {24'h0, `PRI_CB_MISSED};
              o_mem_wdata <= missed_r + 32'h0000_0001;
            end else if (mem_fin) begin
              missed_r <= missed_r + 32'h0000_0001;
              st_r <= S_FIN;
            end
          end
          S_FIN: begin
            o_done <= 1'b1;
            o_retired <= 1'b1;
            if (kind_r) begin
              o_cf_we <= 1'b1;
              o_cf <= ovw_r;
            end
            if (adv_r & flags_r[`PRI_FLG_THRIE] &
                ring_fill(head_r, tail_r, size_r) > thr_r) begin
              o_irq <= 1'b1;
            end
            adv_r <= 1'b0;
            ovw_r <= 1'b0;
            miss_r <= 1'b0;
            st_r <= S_IDLE;
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

/* hdl/pri_regs.vh */
`ifndef PRI_REGS_VH
`define PRI_REGS_VH
// Control block byte offsets, and the index of the last control block load.
`define PRI_CB_FLAGS   8'h00
`define PRI_CB_SIZE    8'h04
`define PRI_CB_BASE    8'h08
`define PRI_CB_HEAD    8'h10
`define PRI_CB_MISSED  8'h18
`define PRI_CB_THRESH  8'h20
`define PRI_CB_TAIL    8'h40
`define PRI_CB_INTV1   8'h80
`define PRI_CB_CNT1    8'h84
`define PRI_LOAD_LAST  3'h6
// Flag bits inside the control block flags word.
`define PRI_FLG_VALEV  1
`define PRI_FLG_CONT   29
`define PRI_FLG_THRIE  31
// Record layout.
`define PRI_REC_BYTES  32'h0000_0020
`define PRI_REC_LAST   3'h7
`define PRI_EVID_VAL   8'h01
`define PRI_EVID_INS   8'hff
// Register map on the AXI4-Lite slave.
`define PRI_R_CBADDR   4'h0
`define PRI_R_STATUS   4'h4
`define PRI_R_HEAD     4'h8
`define PRI_R_MISSED   4'hc
`define PRI_RESP_OKAY  2'b00
`define PRI_RESP_SLV   2'b10
`endif
